// ### jfc_fuse_check.sv
`timescale 1ns/10ps
// Operation
// - fuse continuity check runs on first JTAG access after each power-on reset
// - mode enters on first falling mode-select edge, or if low at power-up, only when a fuse is present and the test terminal is high
// - mode leaves on the second rising mode-select edge since power-up
// - once left, mode stays off, edges ignored, until next power-on reset
// - probe current path on only while mode active and mode-select low
// - test terminal driven low ends the mode and its sense current
// - protection holds only with fuse blown and full-width boot access key
module jfc_fuse_check
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // test pins
   input wire logic tmsPin,
   input wire logic testPin,
   // fuse status and loader key check
   input wire logic fusePresent,
   input wire logic fuseBlown,
   input wire logic fullKeyUsed,
   // outputs
   output logic fuse_probe_current,
   output logic checkActive,
   output logic protectionOk
);
   // ==========================================
   // reset release and pin synchronisers
   // ==========================================
   logic rstMetaReg;
   logic rstSyncB;
   logic tmsSync;
   logic testSync;
   logic tmsPrevReg;
   logic firstReg;
   logic fallEdge;
   logic riseEdge;
   logic [1:0] riseCountReg;
   logic [1:0] riseCountNext;
   jfc_pkg::jfc_state_t stateReg;
   jfc_pkg::jfc_state_t stateNext;

   // reset released through two flops
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstMetaReg <= 1'h0;
         rstSyncB <= 1'h0;
      end
      else
      begin
         rstMetaReg <= 1'h1;
         rstSyncB <= rstMetaReg;
      end
   end

   jfc_sync tmsSyncInst
   (
      .clock(clock),
      .rstSyncB(rstSyncB),
      .pinIn(tmsPin),
      .pinOut(tmsSync)
   );

   jfc_sync testSyncInst
   (
      .clock(clock),
      .rstSyncB(rstSyncB),
      .pinIn(testPin),
      .pinOut(testSync)
   );

   // ==========================================
   // edge detection
   // ==========================================
   // previous sample and first-sample marker
   always_ff @(posedge clock or negedge rstSyncB)
   begin
      if (!rstSyncB)
      begin
         tmsPrevReg <= jfc_pkg::JFC_TMS_IDLE;
         firstReg <= 1'h1;
      end
      else
      begin
         tmsPrevReg <= tmsSync;
         firstReg <= 1'h0;
      end
   end

   // low at the first sample counts as the entry edge
   assign fallEdge = (tmsPrevReg && !tmsSync) || (firstReg && !tmsSync);
   assign riseEdge = !tmsPrevReg && tmsSync && !firstReg;

   // rising edge counter, saturating at the limit
   always_comb
   begin
      riseCountNext = riseCountReg;
      if (riseEdge && riseCountReg != jfc_pkg::JFC_RISE_LIMIT)
      begin
         riseCountNext = riseCountReg + 2'h1;
      end
   end

   always_ff @(posedge clock or negedge rstSyncB)
   begin
      if (!rstSyncB)
      begin
         riseCountReg <= jfc_pkg::JFC_RISE_RESET;
      end
      else
      begin
         riseCountReg <= riseCountNext;
      end
   end

   // ==========================================
   // mode state machine
   // ==========================================
   always_comb
   begin
      stateNext = stateReg;
      case (stateReg)
         jfc_pkg::JFC_ARMED:
         begin
            if (riseCountNext == jfc_pkg::JFC_RISE_LIMIT)
            begin
               stateNext = jfc_pkg::JFC_DONE;
            end
            else if (fallEdge && fusePresent && testSync)
            begin
               stateNext = jfc_pkg::JFC_ACTIVE;
            end
         end
         jfc_pkg::JFC_ACTIVE:
         begin
            if (riseCountNext == jfc_pkg::JFC_RISE_LIMIT || !testSync)
            begin
               stateNext = jfc_pkg::JFC_DONE;
            end
         end
         default:
         begin
            stateNext = jfc_pkg::JFC_DONE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstSyncB)
   begin
      if (!rstSyncB)
      begin
         stateReg <= jfc_pkg::JFC_ARMED;
      end
      else
      begin
         stateReg <= stateNext;
      end
   end

   // ==========================================
   // registered outputs
   // ==========================================
   always_ff @(posedge clock or negedge rstSyncB)
   begin
      if (!rstSyncB)
      begin
         fuse_probe_current <= 1'h0;
         checkActive <= 1'h0;
      end
      else
      begin
         fuse_probe_current <= (stateNext == jfc_pkg::JFC_ACTIVE) && !tmsSync;
         checkActive <= stateNext == jfc_pkg::JFC_ACTIVE;
      end
   end

   always_ff @(posedge clock or negedge rstSyncB)
   begin
      if (!rstSyncB)
      begin
         protectionOk <= 1'h0;
      end
      else
      begin
         protectionOk <= fuseBlown && fullKeyUsed;
      end
   end

   // ==========================================
   // assertions
   // ==========================================
   probe_needs_mode_a: assert property (@(posedge clock) disable iff (!rstSyncB)
      fuse_probe_current |-> checkActive && !$past(tmsSync))
      else $error("probe current without active mode and low select");

   done_stays_a: assert property (@(posedge clock) disable iff (!rstSyncB)
      stateReg == jfc_pkg::JFC_DONE |=> stateReg == jfc_pkg::JFC_DONE)
      else $error("mode left the finished state");

   second_rise_a: assert property (@(posedge clock) disable iff (!rstSyncB)
      riseCountReg == jfc_pkg::JFC_RISE_LIMIT |-> !checkActive)
      else $error("mode active after second rising edge");

   entry_edge_a: assert property (@(posedge clock) disable iff (!rstSyncB)
      stateReg == jfc_pkg::JFC_ARMED && fallEdge && fusePresent && testSync
      && riseCountNext != jfc_pkg::JFC_RISE_LIMIT |=> checkActive)
      else $error("falling edge did not enter the mode");

   test_low_ends_a: assert property (@(posedge clock) disable iff (!rstSyncB)
      !testSync |=> !checkActive && !fuse_probe_current)
      else $error("test terminal low did not end the mode");

   no_fuse_a: assert property (@(posedge clock) disable iff (!rstSyncB)
      !fusePresent && stateReg == jfc_pkg::JFC_ARMED |=> !checkActive)
      else $error("mode entered without a fuse");

   prot_a: assert property (@(posedge clock) disable iff (!rstSyncB)
      protectionOk |-> $past(fuseBlown) && $past(fullKeyUsed))
      else $error("protection flagged without blown fuse and key");

   edge_count_a: assert property (@(posedge clock) disable iff (!rstSyncB)
      riseEdge && riseCountReg == 2'h0 |=> riseCountReg == 2'h1)
      else $error("rising edge not counted");

   enter_c: cover property (@(posedge clock) disable iff (!rstSyncB)
      $rose(checkActive));
   probe_c: cover property (@(posedge clock) disable iff (!rstSyncB)
      $rose(fuse_probe_current));
   leave_c: cover property (@(posedge clock) disable iff (!rstSyncB)
      $fell(checkActive) && riseCountReg == jfc_pkg::JFC_RISE_LIMIT);
endmodule : jfc_fuse_check

// ### jfc_pkg.sv
package jfc_pkg;
   // ==========================================
   // fuse check mode encodings and counts
   // ==========================================
   typedef enum logic [1:0] {JFC_ARMED, JFC_ACTIVE, JFC_DONE} jfc_state_t;
   // rising edges of the mode-select line that end the mode
   localparam logic [1:0] JFC_RISE_LIMIT = 2'h2;
   // reset values
   localparam logic JFC_TMS_IDLE = 1'h1;
   localparam logic [1:0] JFC_RISE_RESET = 2'h0;
endpackage : jfc_pkg

// ### jfc_sync.sv
`timescale 1ns/10ps
// ==========================================
// two-stage synchroniser for a pin level
// ==========================================
module jfc_sync
(
   // clock and reset
   input wire logic clock,
   input wire logic rstSyncB,
   // level in and out
   input wire logic pinIn,
   output logic pinOut
);
   logic stage1Reg;

   // first stage is read only by the second
   always_ff @(posedge clock or negedge rstSyncB)
   begin
      if (!rstSyncB)
      begin
         stage1Reg <= jfc_pkg::JFC_TMS_IDLE;
         pinOut <= jfc_pkg::JFC_TMS_IDLE;
      end
      else
      begin
         stage1Reg <= pinIn;
         pinOut <= stage1Reg;
      end
   end
endmodule : jfc_sync

// ### jfc_jtag_host.sv
`timescale 1ns/10ps
// ==========================================
// external programmer driving the test pins
// ==========================================
module jfc_jtag_host
(
   // clock
   input wire logic clock,
   // wanted pin levels
   input wire logic wantTms,
   input wire logic wantTest,
   // pins toward the device
   output logic tmsPin,
   output logic testPin
);
   // mode-select idles high to keep the probe current off; pins follow one edge late
   initial
   begin
      tmsPin = 1'h1;
      testPin = 1'h1;
      forever
      begin
         @(posedge clock);
         tmsPin <= wantTms;
         testPin <= wantTest;
      end
   end
endmodule : jfc_jtag_host

// ### tb.sv
`timescale 1ns/10ps
// ==========================================
// self-checking bench for the fuse check mode
// ==========================================
module tb;
   logic clock, rst_b, wantTms, wantTest, tmsPin, testPin, tmsM;
   logic fusePresent, fuseBlown, fullKeyUsed, fuse_probe_current, checkActive, protectionOk;
   int miscompares = 0;
   int n_tests = 0;
   int seed = 32'h6834;
   int rises;
   jfc_pkg::jfc_state_t st;
   // ==========================================
   // clock, partner and design
   // ==========================================
   initial
   begin
      clock = 1'h0;
      forever #2.5 clock = ~clock;
   end
   jfc_jtag_host host_u (.clock(clock), .wantTms(wantTms), .wantTest(wantTest),
      .tmsPin(tmsPin), .testPin(testPin));
   jfc_fuse_check dut_u (.clock(clock), .rst_b(rst_b), .tmsPin(tmsPin), .testPin(testPin),
      .fusePresent(fusePresent), .fuseBlown(fuseBlown), .fullKeyUsed(fullKeyUsed),
      .fuse_probe_current(fuse_probe_current), .checkActive(checkActive),
      .protectionOk(protectionOk));
   // ==========================================
   // expectation and reporting
   // ==========================================
   function automatic logic expProbe(jfc_pkg::jfc_state_t s, logic t);
      return (s == jfc_pkg::JFC_ACTIVE) && !t;
   endfunction : expProbe
   task automatic check(logic got, logic exp, string what);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   // one pin move, reference update, then settled compare
   task automatic step(logic t, logic s);
      @(posedge clock);
      #1;
      wantTms = t;
      wantTest = s;
      if (!s && st == jfc_pkg::JFC_ACTIVE)
         st = jfc_pkg::JFC_DONE;
      if (t && !tmsM)
      begin
         rises++;
         if (st != jfc_pkg::JFC_DONE && rises >= int'(jfc_pkg::JFC_RISE_LIMIT))
            st = jfc_pkg::JFC_DONE;
      end
      else if (!t && tmsM && st == jfc_pkg::JFC_ARMED && s && fusePresent)
         st = jfc_pkg::JFC_ACTIVE;
      tmsM = t;
      repeat (8) @(posedge clock);
      #1;
      check(checkActive, st == jfc_pkg::JFC_ACTIVE, "mode");
      check(fuse_probe_current, expProbe(st, t), "probe");
      check(protectionOk, fuseBlown & fullKeyUsed, "protect");
   endtask : step
   // power-on reset with a chosen mode-select level
   task automatic doReset(logic t);
      @(posedge clock);
      #1;
      rst_b = 1'h0;
      wantTms = t;
      wantTest = 1'h1;
      repeat (20) @(posedge clock);
      #1;
      check(checkActive, 1'h0, "reset mode");
      rst_b = 1'h1;
      rises = 0;
      tmsM = t;
      st = (!t && fusePresent) ? jfc_pkg::JFC_ACTIVE : jfc_pkg::JFC_ARMED;
      repeat (8) @(posedge clock);
      #1;
      check(checkActive, st == jfc_pkg::JFC_ACTIVE, "power-up mode");
   endtask : doReset
   // ==========================================
   // scenarios
   // ==========================================
   initial
   begin
      rst_b = 1'h0;
      wantTms = 1'h1;
      wantTest = 1'h1;
      fusePresent = 1'h1;
      fuseBlown = 1'h0;
      fullKeyUsed = 1'h0;
      doReset(1'h1);
      step(1'h0, 1'h1);
      step(1'h1, 1'h1);
      step(1'h0, 1'h1);
      step(1'h1, 1'h1);
      step(1'h0, 1'h1);
      step(1'h1, 1'h1);
      $display("test edge sequence done");
      doReset(1'h0);
      step(1'h1, 1'h1);
      step(1'h0, 1'h1);
      step(1'h0, 1'h0);
      step(1'h1, 1'h1);
      step(1'h0, 1'h1);
      $display("test terminal low done");
      fusePresent = 1'h0;
      doReset(1'h1);
      step(1'h0, 1'h1);
      step(1'h1, 1'h1);
      fusePresent = 1'h1;
      for (int i = 0; i < 4; i++)
      begin
         {fuseBlown, fullKeyUsed} = 2'(i);
         step(tmsM, wantTest);
      end
      $display("test fuse absent and protection done");
      doReset(1'h1);
      repeat (60)
      begin
         fuseBlown = 1'($random(seed));
         fullKeyUsed = 1'($random(seed));
         if ($random(seed) & 1)
            step(!tmsM, wantTest);
         else
            step(tmsM, !wantTest);
      end
      $display("test random done");
      tally_and_finish();
   end
   // watchdog against a hung run
   initial
   begin
      #100000;
      miscompares++;
      $display("BAD %0t run did not finish", $time);
      tally_and_finish();
   end
endmodule : tb
